/* File: hw/ccs_pkg.sv */
// Constants and types shared by the charge stage sequencer
`default_nettype none
package ccs_pkg;
    // APB register byte offsets
    localparam logic [7:0] CCS_OFF_PERIOD = 8'h00;
    localparam logic [7:0] CCS_OFF_STATUS = 8'h04;
    localparam logic [7:0] CCS_OFF_TIMER = 8'h08;
    localparam logic [7:0] CCS_OFF_LBTIME = 8'h0c;
    // End-of-cycle period in clock cycles after reset
    localparam logic [31:0] CCS_PERIOD_RST = 32'h0800_0000;
    // Status register field positions
    localparam int CCS_ST_STATE_LSB = 0;
    localparam int CCS_ST_ALGO_LSB = 4;
    localparam int CCS_ST_EQQ_BIT = 6;
    localparam int CCS_ST_ARMED_BIT = 7;
    localparam int CCS_ST_TMR_BIT = 8;
    localparam int CCS_ST_CHG_BIT = 9;
    localparam int CCS_ST_PH_BIT = 10;
    localparam int CCS_ST_RED_BIT = 11;
    // Equalization and defective-battery shares of the period
    localparam int CCS_SHIFT_QUARTER = 2;
    localparam int CCS_SHIFT_EIGHTH = 3;
    // Synchronised input bit positions
    localparam int CCS_IN_CV = 0;
    localparam int CCS_IN_CL = 1;
    localparam int CCS_IN_LB = 2;
    localparam int CCS_IN_EN = 3;
    localparam int CCS_IN_TMR = 4;
    localparam int CCS_IN_SA = 5;
    localparam int CCS_IN_SB = 7;
    localparam int CCS_IN_W = 9;
    // Three-level strap codes
    localparam logic [1:0] CCS_LVL_LOW = 2'h0;
    localparam logic [1:0] CCS_LVL_MID = 2'h1;
    localparam logic [1:0] CCS_LVL_HIGH = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE, ST_BULK_CC, ST_CV, ST_ABSORB, ST_EQUALIZE, ST_FLOAT, ST_TERM, ST_FAULT
    } ccs_state_t;
    typedef enum logic [1:0] {ALG_TWO, ALG_THREE, ALG_FOUR} ccs_algo_t;
    typedef enum logic [1:0] {LVL_FLOAT, LVL_ABSORB, LVL_EQUALIZE} ccs_level_t;
endpackage
`default_nettype wire

/* File: hw/ccs_sequencer.sv */
// Charge stage sequencer: stage machine, cycle timers, status pins, APB slave
`default_nettype none
module ccs_sequencer
    import ccs_pkg::*;
#(
    parameter logic [31:0] PERIOD_CYCLES = CCS_PERIOD_RST
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cv_loop_active,
    input wire logic current_below_tenth,
    input wire logic feedback_below_threshold,
    input wire logic chip_enable,
    input wire logic cycle_timer_cap,
    input wire logic [1:0] algorithm_select_a,
    input wire logic [1:0] algorithm_select_b,
    output logic charging_flag_out,
    output logic charging_flag_oe,
    output logic phase_flag_out,
    output logic phase_flag_oe,
    output logic [1:0] target_level,
    output logic current_limit_reduce
);
    typedef struct packed {
        ccs_state_t state;
        ccs_algo_t algo;
        logic eq_quarter;
        logic eq_armed;
        logic [31:0] period;
        logic [31:0] acc;
        logic [31:0] lb_cnt;
        logic chg_oe;
        logic ph_oe;
        ccs_level_t level;
        logic reduce;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } ccs_regs_t;
    ccs_regs_t q;
    ccs_regs_t d;

    logic [CCS_IN_W-1:0] raw_in;
    logic [CCS_IN_W-1:0] syn;
    logic cv_s;
    logic cl_s;
    logic lb_s;
    logic en_s;
    logic tmr_s;
    logic [1:0] sa_s;
    logic [1:0] sb_s;

    // Comparators, enable, timer presence and straps cross into pclk
    assign raw_in = {algorithm_select_b, algorithm_select_a, cycle_timer_cap, chip_enable,
                     feedback_below_threshold, current_below_tenth, cv_loop_active};
    ccs_sync #(.W(CCS_IN_W)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_i(raw_in),
        .sync_o(syn)
    );
    assign cv_s = syn[CCS_IN_CV];
    assign cl_s = syn[CCS_IN_CL];
    assign lb_s = syn[CCS_IN_LB];
    assign en_s = syn[CCS_IN_EN];
    assign tmr_s = syn[CCS_IN_TMR];
    assign sa_s = syn[CCS_IN_SA +: 2];
    assign sb_s = syn[CCS_IN_SB +: 2];

    // Strap decode into algorithm; lithium combinations fall back to two-stage
    function automatic ccs_algo_t decode_algo(input logic [1:0] a, input logic [1:0] b);
        if (b == CCS_LVL_HIGH) begin
            return ALG_FOUR;
        end else if (b == CCS_LVL_LOW && a != CCS_LVL_LOW) begin
            return ALG_THREE;
        end else begin
            return ALG_TWO;
        end
    endfunction

    // Which states actively charge the battery
    function automatic logic is_active(input ccs_state_t s);
        return s == ST_BULK_CC || s == ST_CV || s == ST_ABSORB || s == ST_EQUALIZE;
    endfunction

    logic timer_done;
    logic eq_done;
    logic lb_expired;
    logic [31:0] eq_limit;

    // Timer thresholds derived from the shared end-of-cycle period
    always_comb begin
        timer_done = q.acc >= q.period;
        eq_limit = q.eq_quarter ? (q.period >> CCS_SHIFT_QUARTER)
                                : (q.period >> CCS_SHIFT_EIGHTH);
        eq_done = q.acc >= eq_limit;
        lb_expired = q.lb_cnt > (q.period >> CCS_SHIFT_EIGHTH);
    end

    // Next-state logic: stage machine, timers, pins, bus slave
    always_comb begin
        d = q;
        unique case (q.state)
            ST_IDLE: begin
                if (en_s) begin
                    d.eq_armed = 1'b1;
                    d.algo = decode_algo(sa_s, sb_s);
                    d.eq_quarter = sa_s == CCS_LVL_LOW;
                    d.state = d.algo == ALG_TWO ? ST_BULK_CC : ST_ABSORB;
                    d.acc = '0;
                    d.lb_cnt = '0;
                end
            end
            ST_BULK_CC: begin
                if (cv_s) begin
                    d.state = ST_CV;
                    d.acc = '0;
                end
            end
            ST_CV: begin
                if (tmr_s && cv_s) begin
                    d.acc = q.acc + 32'h1;
                end
                if (tmr_s && timer_done) begin
                    d.state = ST_TERM;
                end
            end
            ST_ABSORB: begin
                if (!tmr_s) begin
                    if (cl_s) begin
                        d.state = ST_FLOAT;
                    end
                end else begin
                    if (cv_s) begin
                        d.acc = q.acc + 32'h1;
                    end
                    if (timer_done) begin
                        d.acc = '0;
                        if (q.algo == ALG_FOUR && q.eq_armed) begin
                            d.state = ST_EQUALIZE;
                            d.eq_armed = 1'b0;
                        end else begin
                            d.state = ST_FLOAT;
                        end
                    end
                end
            end
            ST_EQUALIZE: begin
                d.acc = q.acc + 32'h1;
                if (eq_done || !tmr_s) begin
                    d.state = ST_FLOAT;
                end
            end
            ST_FLOAT, ST_TERM: begin
                if (lb_s) begin
                    d.state = q.algo == ALG_TWO ? ST_BULK_CC : ST_ABSORB;
                    d.acc = '0;
                    d.lb_cnt = '0;
                end
            end
            ST_FAULT: begin
                d.state = ST_FAULT;
            end
        endcase
        // Defective-battery timing counts only below threshold with timer present
        if (is_active(q.state) && tmr_s) begin
            if (lb_s) begin
                d.lb_cnt = q.lb_cnt + 32'h1;
            end
            if (lb_expired) begin
                d.state = ST_FAULT;
            end
        end
        // Dropping enable returns to idle; rising again rearms a full cycle
        if (!en_s) begin
            d.state = ST_IDLE;
        end
        // Status pins and analog controls follow the next state
        d.chg_oe = is_active(d.state) || d.state == ST_FLOAT;
        d.ph_oe = d.state == ST_CV || d.state == ST_FLOAT || d.state == ST_FAULT;
        d.level = d.state == ST_ABSORB ? LVL_ABSORB
                : d.state == ST_EQUALIZE ? LVL_EQUALIZE : LVL_FLOAT;
        d.reduce = d.state == ST_EQUALIZE || (is_active(d.state) && tmr_s && lb_s);
        // APB: one wait state, write commits on the completing edge
        d.ready = psel && penable && !q.ready;
        if (psel && penable && !q.ready) begin
            d.err = 1'b0;
            d.rdata = '0;
            unique case (paddr)
                CCS_OFF_PERIOD: d.rdata = q.period;
                CCS_OFF_STATUS: begin
                    d.rdata[CCS_ST_STATE_LSB +: 3] = q.state;
                    d.rdata[CCS_ST_ALGO_LSB +: 2] = q.algo;
                    d.rdata[CCS_ST_EQQ_BIT] = q.eq_quarter;
                    d.rdata[CCS_ST_ARMED_BIT] = q.eq_armed;
                    d.rdata[CCS_ST_TMR_BIT] = tmr_s;
                    d.rdata[CCS_ST_CHG_BIT] = q.chg_oe;
                    d.rdata[CCS_ST_PH_BIT] = q.ph_oe;
                    d.rdata[CCS_ST_RED_BIT] = q.reduce;
                end
                CCS_OFF_TIMER: d.rdata = q.acc;
                CCS_OFF_LBTIME: d.rdata = q.lb_cnt;
                default: d.err = 1'b1;
            endcase
            if (pwrite && paddr != CCS_OFF_PERIOD) begin
                d.err = 1'b1;
            end
        end
        if (psel && penable && q.ready && pwrite && paddr == CCS_OFF_PERIOD) begin
            d.period = pwdata;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.period <= PERIOD_CYCLES;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops; open-drain pins only ever pull low
    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.err;
    assign charging_flag_out = 1'b0;
    assign phase_flag_out = 1'b0;
    assign charging_flag_oe = q.chg_oe;
    assign phase_flag_oe = q.ph_oe;
    assign target_level = q.level;
    assign current_limit_reduce = q.reduce;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_start;
        q.state == ST_IDLE ##1 q.state != ST_IDLE |-> q.chg_oe && !q.ph_oe;
    endproperty
    a_start: assert property (p_start) else $error("start lacks charging flag");

    property p_fault_pins;
        q.state == ST_FAULT |-> !q.chg_oe && q.ph_oe;
    endproperty
    a_fault_pins: assert property (p_fault_pins) else $error("fault pin pattern wrong");

    property p_term;
        q.state == ST_CV && tmr_s && en_s && !lb_s && q.acc >= q.period && !lb_expired
            |=> q.state == ST_TERM && !q.chg_oe && !q.ph_oe;
    endproperty
    a_term: assert property (p_term) else $error("two-stage did not terminate");

    property p_forever;
        q.state == ST_CV && !tmr_s |=> q.state != ST_TERM;
    endproperty
    a_forever: assert property (p_forever) else $error("untimed cv terminated");

    property p_reduce;
        tmr_s && lb_s && en_s && is_active(q.state) && !lb_expired |=> q.reduce;
    endproperty
    a_reduce: assert property (p_reduce) else $error("current not reduced");

    property p_eq_entry;
        q.state == ST_ABSORB ##1 q.state == ST_EQUALIZE
            |-> q.acc == 32'h0 && q.level == LVL_EQUALIZE && q.reduce;
    endproperty
    a_eq_entry: assert property (p_eq_entry) else $error("bad equalize entry");

    property p_once;
        $rose(q.state == ST_EQUALIZE) |-> $past(q.eq_armed) && !q.eq_armed;
    endproperty
    a_once: assert property (p_once) else $error("second equalization");

    property p_untimed_absorb;
        q.state == ST_ABSORB && !tmr_s && cl_s && en_s |=> q.state == ST_FLOAT ##0 q.ph_oe;
    endproperty
    a_untimed_absorb: assert property (p_untimed_absorb) else $error("no float");

    property p_no_eq;
        q.state == ST_ABSORB && !tmr_s |=> q.state != ST_EQUALIZE;
    endproperty
    a_no_eq: assert property (p_no_eq) else $error("equalize without timer");

    property p_float_pins;
        q.state == ST_FLOAT |-> q.chg_oe && q.ph_oe && q.level == LVL_FLOAT;
    endproperty
    a_float_pins: assert property (p_float_pins) else $error("float pins wrong");

    // Timer pause, timer-gated faults and staged restarts
    property p_pause;
        q.state == ST_ABSORB && tmr_s && !cv_s && !timer_done |=> $stable(q.acc);
    endproperty
    a_pause: assert property (p_pause) else $error("timer ran outside cv");

    property p_no_timer_fault;
        !tmr_s && q.state != ST_FAULT |=> q.state != ST_FAULT;
    endproperty
    a_no_timer_fault: assert property (p_no_timer_fault) else $error("fault without timer");

    property p_restart_staged;
        q.state == ST_FLOAT && lb_s && en_s && q.algo != ALG_TWO
            |=> q.state == ST_ABSORB && q.acc == 32'h0;
    endproperty
    a_restart_staged: assert property (p_restart_staged) else $error("no fresh absorb");

    c_fault: cover property (q.state != ST_FAULT ##1 q.state == ST_FAULT);
    c_eq_done: cover property (q.state == ST_EQUALIZE ##1 q.state == ST_FLOAT);
    c_term: cover property (q.state == ST_CV ##1 q.state == ST_TERM);
    c_restart: cover property (q.state == ST_TERM ##1 q.state == ST_BULK_CC);
endmodule
`default_nettype wire

/* File: hw/ccs_sync.sv */
// Two-flop synchroniser for a group of asynchronous inputs
`default_nettype none
module ccs_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ccs_sync_t;
    ccs_sync_t q;
    ccs_sync_t d;

    // First stage feeds only the second stage
    always_comb begin
        d = q;
        d.meta = async_i;
        d.stable = q.meta;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Output per bit from the second stage
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign sync_o[i] = q.stable[i];
    end
endmodule
`default_nettype wire

/* File: verification/ccs_power_stage.sv */
// Model of the power stage, battery, mode straps and status lamps
`default_nettype none
module ccs_power_stage (
    input wire logic charging_flag_out,
    input wire logic charging_flag_oe,
    input wire logic phase_flag_out,
    input wire logic phase_flag_oe,
    input wire logic [1:0] strap_a,
    input wire logic [1:0] strap_b,
    input wire logic bat_full,
    input wire logic bat_low,
    input wire logic taper,
    output logic cv_loop_active,
    output logic current_below_tenth,
    output logic feedback_below_threshold,
    output logic [1:0] algorithm_select_a,
    output logic [1:0] algorithm_select_b,
    output logic charging_pin,
    output logic phase_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Straps tied low or high, or left open which reads as mid
    assign algorithm_select_a = strap_a;
    assign algorithm_select_b = strap_b;
    // Voltage loop regulates only while current is delivered
    assign cv_loop_active = bat_full & charging_flag_oe;
    assign current_below_tenth = cv_loop_active & taper;
    assign feedback_below_threshold = bat_low;
    // Open-drain lamps with pull-ups: a released pin reads high
    assign charging_pin = charging_flag_oe ? charging_flag_out : 1'b1;
    assign phase_pin = phase_flag_oe ? phase_flag_out : 1'b1;
endmodule
`default_nettype wire

/* File: verification/ccs_sequencer_tb.sv */
// Self-checking bench for the charge stage sequencer
`default_nettype none
module ccs_sequencer_tb
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] a;
        logic [1:0] b;
        logic [1:0] algo;
        logic eqq;
    } ccs_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, st;
    logic cv_loop_active, current_below_tenth, feedback_below_threshold;
    logic chip_enable, cycle_timer_cap, bat_full, bat_low, taper;
    logic [1:0] strap_a, strap_b, algorithm_select_a, algorithm_select_b, target_level;
    logic charging_flag_out, charging_flag_oe, phase_flag_out, phase_flag_oe;
    logic current_limit_reduce, charging_pin, phase_pin;
    logic [4:0] obs;
    int fail_count, num_checks;
    int eq_count = 0;
    int eq_mark;
    ccs_row_t rows [9];

    ccs_sequencer i_ccs_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cv_loop_active, .current_below_tenth,
        .feedback_below_threshold, .chip_enable, .cycle_timer_cap, .algorithm_select_a,
        .algorithm_select_b, .charging_flag_out, .charging_flag_oe, .phase_flag_out,
        .phase_flag_oe, .target_level, .current_limit_reduce);
    ccs_power_stage i_ccs_power_stage (.charging_flag_out, .charging_flag_oe,
        .phase_flag_out, .phase_flag_oe, .strap_a, .strap_b, .bat_full, .bat_low, .taper,
        .cv_loop_active, .current_below_tenth, .feedback_below_threshold,
        .algorithm_select_a, .algorithm_select_b, .charging_pin, .phase_pin);

    // Observed lamps (on = pulled low), target level and current cut
    assign obs = {~charging_pin, ~phase_pin, target_level, current_limit_reduce};

    // Clock of 20 ns period
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Counts cycles spent at the equalization level
    always @(posedge pclk) begin
        if (target_level === 2'h2) eq_count <= eq_count + 1;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; pready, read data and error are taken at the completing rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        cmp(32'(n < 20), 32'h1);
        @(posedge pclk);
    endtask

    // Waits for masked outputs to match, no sooner than lo cycles, at most hi
    task automatic wait_pins(input int lo, input int hi, input logic [4:0] e,
                             input logic [4:0] m);
        int n;
        n = 0;
        @(negedge pclk);
        while (((obs ^ e) & m) !== 5'h0 && n < hi) begin
            @(negedge pclk);
            n++;
        end
        cmp(32'(obs & m), 32'(e & m));
        cmp(32'(n >= lo), 32'h1);
        @(posedge pclk);
    endtask

    // Enable cycle with new straps and timer setting
    task automatic restart(input logic [1:0] a, input logic [1:0] b, input logic t);
        chip_enable <= 1'b0;
        bat_full <= 1'b0;
        bat_low <= 1'b0;
        taper <= 1'b0;
        strap_a <= a;
        strap_b <= b;
        cycle_timer_cap <= t;
        repeat (5) @(posedge pclk);
        wait_pins(0, 1, 5'h00, 5'h1f);
        chip_enable <= 1'b1;
        wait_pins(0, 8, 5'h10, 5'h18);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        chip_enable = 1'b0;
        cycle_timer_cap = 1'b0;
        strap_a = 2'h0;
        strap_b = 2'h0;
        bat_full = 1'b0;
        bat_low = 1'b0;
        taper = 1'b0;
        fail_count = 0;
        num_checks = 0;
        rows = '{'{2'h0, 2'h0, 2'h0, 1'b0}, '{2'h0, 2'h1, 2'h0, 1'b0},
                 '{2'h1, 2'h1, 2'h0, 1'b0}, '{2'h2, 2'h1, 2'h0, 1'b0},
                 '{2'h1, 2'h0, 2'h1, 1'b0}, '{2'h2, 2'h0, 2'h1, 1'b0},
                 '{2'h0, 2'h2, 2'h2, 1'b1}, '{2'h2, 2'h2, 2'h2, 1'b0},
                 '{2'h1, 2'h2, 2'h2, 1'b0}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Register map: reset value, short period, refused accesses
        apb(1'b0, CCS_OFF_PERIOD, 32'h0, st, err);
        cmp(st, CCS_PERIOD_RST);
        apb(1'b1, CCS_OFF_PERIOD, 32'h40, st, err);
        cmp(32'(err), 32'h0);
        apb(1'b0, CCS_OFF_PERIOD, 32'h0, st, err);
        cmp(st, 32'h40);
        apb(1'b0, 8'h10, 32'h0, st, err);
        cmp(32'(err), 32'h1);
        apb(1'b1, CCS_OFF_STATUS, 32'hffff_ffff, st, err);
        cmp(32'(err), 32'h1);
        // Strap table: algorithm and equalization share
        foreach (rows[i]) begin
            restart(rows[i].a, rows[i].b, 1'b1);
            apb(1'b0, CCS_OFF_STATUS, 32'h0, st, err);
            cmp(32'(st[CCS_ST_ALGO_LSB +: 2]), 32'(rows[i].algo));
            cmp(32'(st[CCS_ST_TMR_BIT]), 32'h1);
            if (rows[i].algo == 2'h2) cmp(32'(st[CCS_ST_EQQ_BIT]), 32'(rows[i].eqq));
        end
        // Two-stage timed: CV flag, termination, low-battery restart, fault
        restart(2'h0, 2'h0, 1'b1);
        bat_full <= 1'b1;
        wait_pins(0, 6, 5'h18, 5'h1f);
        wait_pins(55, 75, 5'h00, 5'h18);
        apb(1'b0, CCS_OFF_TIMER, 32'h0, st, err);
        cmp(32'(st >= 32'h40), 32'h1);
        bat_full <= 1'b0;
        bat_low <= 1'b1;
        wait_pins(0, 6, 5'h11, 5'h19);
        wait_pins(3, 20, 5'h08, 5'h18);
        apb(1'b0, CCS_OFF_LBTIME, 32'h0, st, err);
        cmp(32'(st > 32'h8), 32'h1);
        // Four-stage timed: equalize once, then a low-battery cycle without it
        restart(2'h0, 2'h2, 1'b1);
        bat_full <= 1'b1;
        wait_pins(0, 6, 5'h12, 5'h1f);
        wait_pins(55, 75, 5'h15, 5'h1f);
        wait_pins(12, 22, 5'h18, 5'h1f);
        eq_mark = eq_count;
        bat_low <= 1'b1;
        wait_pins(0, 6, 5'h13, 5'h1f);
        bat_low <= 1'b0;
        wait_pins(55, 80, 5'h18, 5'h1f);
        cmp(32'(eq_count - eq_mark), 32'h0);
        // Four-stage with the eighth share: shorter equalization
        restart(2'h2, 2'h2, 1'b1);
        bat_full <= 1'b1;
        wait_pins(55, 75, 5'h15, 5'h1f);
        wait_pins(4, 12, 5'h18, 5'h1f);
        // Untimed three-stage and four-stage: current taper ends absorption
        for (int k = 0; k < 2; k++) begin
            restart(k == 0 ? 2'h1 : 2'h0, k == 0 ? 2'h0 : 2'h2, 1'b0);
            eq_mark = eq_count;
            bat_full <= 1'b1;
            wait_pins(0, 6, 5'h12, 5'h1f);
            taper <= 1'b1;
            wait_pins(0, 6, 5'h18, 5'h1f);
            taper <= 1'b0;
            bat_low <= 1'b1;
            wait_pins(0, 8, 5'h12, 5'h1f);
            cmp(32'(eq_count - eq_mark), 32'h0);
        end
        // Two-stage untimed holds CV with no termination
        restart(2'h0, 2'h0, 1'b0);
        bat_full <= 1'b1;
        wait_pins(0, 6, 5'h18, 5'h1f);
        repeat (150) @(posedge pclk);
        wait_pins(0, 1, 5'h18, 5'h1f);
        // Power cycle in mid-charge: all off, period restored, a fresh armed cycle
        presetn <= 1'b0;
        wait_pins(0, 1, 5'h00, 5'h1f);
        presetn <= 1'b1;
        apb(1'b0, CCS_OFF_PERIOD, 32'h0, st, err);
        cmp(st, CCS_PERIOD_RST);
        wait_pins(0, 8, 5'h18, 5'h1f);
        apb(1'b0, CCS_OFF_STATUS, 32'h0, st, err);
        cmp(32'(st[CCS_ST_ARMED_BIT]), 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
